// ---- rtl/pac_defs.svh ----
// register offsets, reset values and pin constants for the port A pin control block
`ifndef PAC_DEFS_SVH
`define PAC_DEFS_SVH
`define PAC_ADDR_W        3
`define PAC_ADDR_LEVEL    3'h0
`define PAC_ADDR_LATCH    3'h1
`define PAC_ADDR_DIR      3'h2
`define PAC_ADDR_ANALOG_PIN_SELECT    3'h3
`define PAC_ADDR_OSC      3'h4
`define PAC_RST_LATCH     8'h00
`define PAC_RST_DIR       8'hFF
`define PAC_RST_ANALOG_PIN_SELECT     8'h1F
`define PAC_RST_OSC       2'h0
`define PAC_RST_DIV       2'h0
`define PAC_ZERO8         8'h00
`define PAC_ALL8          8'hFF
`define PAC_OSC_PINS      8'hC0
`define PAC_CYCLE_CLOCK_OUT_PIN      3'h6
`define PAC_XTAL_IN_PIN   3'h7
`define PAC_TMR0_PIN      3'h4
`define PAC_TMR1_PIN      3'h5
`define PAC_DIV_STEP      2'h1
`define PAC_CYCLE_CLOCK_OUT_BIT      1
`endif

// ---- rtl/pac_pkg.sv ----
// types and shared decode for the port A pin control block
package pac_pkg;
    typedef enum logic [1:0] {
        PAC_OSC_INT_IO   = 2'b00,
        PAC_OSC_INT_CYCLE_CLOCK_OUT = 2'b01,
        PAC_OSC_EXT_CLK  = 2'b10,
        PAC_OSC_EXT_XTAL = 2'b11
    } pac_osc_e;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] analog_pin_select;
        pac_osc_e   osc;
        logic [1:0] div;
        logic [7:0] rdata;
        logic [7:0] pad_out;
        logic [7:0] pad_oe;
        logic [7:0] ana_en;
        logic       tmr0;
        logic       tmr1;
        logic       tmr3g;
    } pac_state_s;

    // channels 0..3 sit on pins 0..3, channel 4 on pin 5; pin 4 has no analog use
    function automatic logic [7:0] pac_analog_pins(input logic [7:0] analog_pin_select);
        pac_analog_pins = {2'b00, analog_pin_select[4], 1'b0, analog_pin_select[3:0]};
    endfunction : pac_analog_pins

    // oscillator_pin_config: set for either external oscillator mode
    function automatic logic pac_osc_pin_cfg(input pac_osc_e osc);
        pac_osc_pin_cfg = osc[1];
    endfunction : pac_osc_pin_cfg
endpackage : pac_pkg

// ---- rtl/pac_mux_if.sv ----
// carrier between the register core and the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
interface pac_mux_if;
    import pac_pkg::*;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] analog_pin_select;
    pac_osc_e   osc;
    logic       cycle_clock_out;
    logic [7:0] pad_in;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] level;
    logic [7:0] pin_en;
    logic [7:0] ana;
    modport ctl (output latch, dir, analog_pin_select, osc, cycle_clock_out, pad_in, input pad_out, pad_oe, level, pin_en, ana);
    modport mux (input latch, dir, analog_pin_select, osc, cycle_clock_out, pad_in, output pad_out, pad_oe, level, pin_en, ana);
endinterface : pac_mux_if
`default_nettype wire

// ---- rtl/pac_pin_mux.sv ----
// combinational pin multiplexer: drive, enable and input gating per pin
`timescale 1ns/1ps
`default_nettype none
`include "pac_defs.svh"
module pac_pin_mux (
    pac_mux_if.mux m
);
    import pac_pkg::*;

    logic cycle_clock_out_mode;

    always_comb
    begin
        case (m.osc)
            PAC_OSC_INT_IO:   cycle_clock_out_mode = 1'b0;
            PAC_OSC_INT_CYCLE_CLOCK_OUT: cycle_clock_out_mode = 1'b1;
            PAC_OSC_EXT_CLK:  cycle_clock_out_mode = 1'b1;
            PAC_OSC_EXT_XTAL: cycle_clock_out_mode = 1'b0;
            default:          cycle_clock_out_mode = 1'b0;
        endcase
    end

    always_comb
    begin
        m.pin_en = `PAC_ALL8;
        if (pac_osc_pin_cfg(m.osc))
        begin
            m.pin_en = ~`PAC_OSC_PINS;                     // see [R6]
        end
        if (cycle_clock_out_mode)
        begin
            m.pin_en[`PAC_CYCLE_CLOCK_OUT_PIN] = 1'b0;
        end
        m.ana    = pac_analog_pins(m.analog_pin_select);               // see [R4]
        // drive ignores analog select entirely
        m.pad_out = m.latch & m.pin_en;                    // see [R1]
        m.pad_oe  = ~m.dir & m.pin_en;                     // see [R1] see [R11]
        if (cycle_clock_out_mode)
        begin
            m.pad_out[`PAC_CYCLE_CLOCK_OUT_PIN] = m.cycle_clock_out;             // see [R7]
            m.pad_oe[`PAC_CYCLE_CLOCK_OUT_PIN]  = 1'b1;
        end
        // analog or oscillator-owned pins read as zero
        m.level = m.pad_in & ~m.ana & m.pin_en;            // see [R2] see [R9] see [R6]
    end
endmodule : pac_pin_mux
`default_nettype wire

// ---- rtl/pac_port_a.sv ----
// port A pin control: registers, pin drive, readback and shared peripheral inputs
//
// Notes on behaviour
// [R1] direction 0 drives the pin from its latch; analog select never alters it
// [R2] direction 1 shows the pin level on read; analog pins read no digital level
// [R3] after reset pins 0-3 and 5 are analog channels; drive path unaffected
// [R4] after reset pin 4 is a digital input with no analog function
// [R5] timer clock and gate inputs on pins 4 and 5 follow the pin, ignoring direction
// [R6] external oscillator configuration disables digital input and output of pins 6 and 7; in external clock mode pin 6 still drives the cycle clock
// [R7] in clock-out modes pin 6 carries the oscillator clock divided by four
// [R8] bits 6 and 7 exist only when the oscillator mode frees those pins
// [R9] on any reset pins 0-3 and 5 are analog and read zero
// [R10] software keeps direction set on pins used as analog inputs
// [R11] internal oscillator mode makes pins 6 and 7 ordinary digital I/O; in PAC_OSC_INT_CYCLE_CLOCK_OUT pin 6 carries the cycle clock instead
// [R12] port or latch writes update the latch; latch reads return latch contents
`timescale 1ns/1ps
`default_nettype none
`include "pac_defs.svh"
module pac_port_a (
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    input  wire logic [`PAC_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [7:0]             rdata_o,
    input  wire logic [7:0]             pad_in_i,
    output logic      [7:0]             pad_out_o,
    output logic      [7:0]             pad_oe_o,
    output logic      [7:0]             analog_en_o,
    output var pac_pkg::pac_osc_e       osc_mode_o,
    output logic                        timer_zero_clock_in_o,
    output logic                        timer_one_clock_in_o,
    output logic                        timer_three_gate_in_o
);
    import pac_pkg::*;

    pac_state_s st_reg;
    pac_state_s st_next;
    pac_mux_if  mx ();

    pac_pin_mux u_mux (
        .m (mx.mux)
    );

    assign mx.latch  = st_reg.latch;
    assign mx.dir    = st_reg.dir;
    assign mx.analog_pin_select  = st_reg.analog_pin_select;
    assign mx.osc    = st_reg.osc;
    assign mx.cycle_clock_out   = st_reg.div[`PAC_CYCLE_CLOCK_OUT_BIT];
    assign mx.pad_in = pad_in_i;

    // merge a write into a register, leaving oscillator-owned bits untouched
    function automatic logic [7:0] pac_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] en);
        pac_merge = (new_v & en) | (old_v & ~en);
    endfunction : pac_merge

    always_comb
    begin
        st_next     = st_reg;
        st_next.div = st_reg.div + `PAC_DIV_STEP;           // see [R7]
        if (wr_i)
        begin
            case (addr_i)
                `PAC_ADDR_LEVEL: st_next.latch = pac_merge(st_reg.latch, wdata_i, mx.pin_en); // see [R12] see [R8]
                `PAC_ADDR_LATCH: st_next.latch = pac_merge(st_reg.latch, wdata_i, mx.pin_en); // see [R12] see [R8]
                `PAC_ADDR_DIR:   st_next.dir   = pac_merge(st_reg.dir, wdata_i, mx.pin_en);   // see [R8]
                `PAC_ADDR_ANALOG_PIN_SELECT: st_next.analog_pin_select = wdata_i;
                `PAC_ADDR_OSC:   st_next.osc   = pac_osc_e'(wdata_i[1:0]);
                default:         st_next.analog_pin_select = st_reg.analog_pin_select;
            endcase
        end
        st_next.rdata = `PAC_ZERO8;
        if (rd_i)
        begin
            case (addr_i)
                `PAC_ADDR_LEVEL: st_next.rdata = mx.level;                    // see [R2] see [R9]
                `PAC_ADDR_LATCH: st_next.rdata = st_reg.latch & mx.pin_en;    // see [R12] see [R8]
                `PAC_ADDR_DIR:   st_next.rdata = st_reg.dir & mx.pin_en;      // see [R8]
                `PAC_ADDR_ANALOG_PIN_SELECT: st_next.rdata = st_reg.analog_pin_select;
                `PAC_ADDR_OSC:   st_next.rdata = {6'h00, st_reg.osc};
                default:         st_next.rdata = `PAC_ZERO8;
            endcase
        end
        st_next.pad_out = mx.pad_out;                       // see [R1]
        st_next.pad_oe  = mx.pad_oe;                        // see [R6] see [R11]
        st_next.ana_en  = mx.ana;                           // see [R3]
        // timer inputs tap the raw pad, so direction has no say
        st_next.tmr0    = pad_in_i[`PAC_TMR0_PIN];          // see [R5]
        st_next.tmr1    = pad_in_i[`PAC_TMR1_PIN];          // see [R5]
        st_next.tmr3g   = pad_in_i[`PAC_TMR1_PIN];          // see [R5]
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg.latch   <= `PAC_RST_LATCH;
            // all inputs at reset, as analog use expects
            st_reg.dir     <= `PAC_RST_DIR;                 // see [R10]
            st_reg.analog_pin_select   <= `PAC_RST_ANALOG_PIN_SELECT;               // see [R3] see [R9]
            st_reg.osc     <= pac_osc_e'(`PAC_RST_OSC);
            st_reg.div     <= `PAC_RST_DIV;
            st_reg.rdata   <= `PAC_ZERO8;
            st_reg.pad_out <= `PAC_ZERO8;
            st_reg.pad_oe  <= `PAC_ZERO8;
            st_reg.ana_en  <= `PAC_ZERO8;
            st_reg.tmr0    <= 1'b0;
            st_reg.tmr1    <= 1'b0;
            st_reg.tmr3g   <= 1'b0;
        end
        else if (ce_i)
        begin
            st_reg <= st_next;
        end
    end

    assign rdata_o               = st_reg.rdata;
    assign pad_out_o             = st_reg.pad_out;
    assign pad_oe_o              = st_reg.pad_oe;
    assign analog_en_o           = st_reg.ana_en;
    assign osc_mode_o            = st_reg.osc;
    assign timer_zero_clock_in_o = st_reg.tmr0;
    assign timer_one_clock_in_o  = st_reg.tmr1;
    assign timer_three_gate_in_o = st_reg.tmr3g;

    // helpers for the checks below
    logic cycle_clock_out_mode;
    assign cycle_clock_out_mode = (st_reg.osc == PAC_OSC_INT_CYCLE_CLOCK_OUT) || (st_reg.osc == PAC_OSC_EXT_CLK);

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_drive_ignores_analog: assert property ( // see [R1]
        ce_i && !st_reg.dir[1] && st_reg.analog_pin_select[1] |=> pad_oe_o[1] && pad_out_o[1] == $past(st_reg.latch[1]))
        else $error("pin 1 drive does not follow latch");

    a_analog_reads_zero: assert property ( // see [R2]
        ce_i && rd_i && addr_i == `PAC_ADDR_LEVEL && st_reg.analog_pin_select[0] |=> rdata_o[0] == 1'b0)
        else $error("analog pin 0 read a digital level");

    a_reset_analog_default: assert property ( // see [R3]
        $past(rst_i) && !rst_i |-> st_reg.analog_pin_select == `PAC_RST_ANALOG_PIN_SELECT && analog_en_o == `PAC_ZERO8)
        else $error("analog select not at reset default");

    a_pin4_digital_read: assert property ( // see [R4]
        ce_i && rd_i && addr_i == `PAC_ADDR_LEVEL |=> rdata_o[4] == $past(pad_in_i[4]))
        else $error("pin 4 level not returned");

    a_timer_in_follow: assert property ( // see [R5]
        ce_i && st_reg.dir[5] == 1'b0 |=> timer_one_clock_in_o == $past(pad_in_i[5])
                                        && timer_three_gate_in_o == $past(pad_in_i[5]))
        else $error("timer input ignores pad level");

    a_osc_pins_off: assert property ( // see [R6]
        ce_i && pac_osc_pin_cfg(st_reg.osc) |=> !pad_oe_o[7] && !pad_out_o[7])
        else $error("pin 7 driven in external oscillator mode");

    a_cycle_clock_out_quarter_rate: assert property ( // see [R7]
        (ce_i && cycle_clock_out_mode)[*5] |-> pad_out_o[6] != $past(pad_out_o[6], 2) && pad_oe_o[6])
        else $error("cycle clock not at one quarter rate");

    a_hidden_bits_zero: assert property ( // see [R8]
        ce_i && rd_i && addr_i == `PAC_ADDR_LATCH && pac_osc_pin_cfg(st_reg.osc) |=> rdata_o[7:6] == 2'b00)
        else $error("oscillator-owned latch bits readable");

    // reset loads the analog selection with its default, so this holds for every read until software clears it
    a_reset_reads_zero: assert property ( // see [R9]
        ce_i && rd_i && addr_i == `PAC_ADDR_LEVEL && (st_reg.analog_pin_select & `PAC_RST_ANALOG_PIN_SELECT) == `PAC_RST_ANALOG_PIN_SELECT
        |=> (rdata_o & pac_analog_pins(`PAC_RST_ANALOG_PIN_SELECT)) == `PAC_ZERO8)
        else $error("analog pins read nonzero after reset");

    a_int_osc_io: assert property ( // see [R11]
        ce_i && st_reg.osc == PAC_OSC_INT_IO && !st_reg.dir[7] |=> pad_oe_o[7] && pad_out_o[7] == $past(st_reg.latch[7]))
        else $error("pin 7 not digital in internal oscillator mode");

    a_latch_write_read: assert property ( // see [R12]
        ce_i && wr_i && addr_i == `PAC_ADDR_LEVEL && st_reg.osc == PAC_OSC_INT_IO
        ##1 ce_i && rd_i && addr_i == `PAC_ADDR_LATCH |=> rdata_o == $past(wdata_i, 2))
        else $error("latch readback differs from port write");

    c_pin_drive: cover property (ce_i && !st_reg.dir[0] ##1 pad_oe_o[0]);
    c_cycle_clock_out_run: cover property ((ce_i && cycle_clock_out_mode)[*6]);
    c_level_read: cover property (ce_i && rd_i && addr_i == `PAC_ADDR_LEVEL ##1 rdata_o != `PAC_ZERO8);
    c_ext_osc: cover property (ce_i && wr_i && addr_i == `PAC_ADDR_OSC && wdata_i[1]);
endmodule : pac_port_a
`default_nettype wire

// ---- dv/pac_pad_model.sv ----
// pad-side model: external drivers plus whatever the port drives back onto its own pins
`timescale 1ns/1ps
`default_nettype none
module pac_pad_model (
    input  wire logic [7:0] pad_out_i,
    input  wire logic [7:0] pad_oe_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] pad_in_o
);
    // a driven pin shows the port's own drive; the outside source is assumed to back off
    assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule : pac_pad_model
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the port A pin control block
`timescale 1ns/1ps
`default_nettype none
`include "pac_defs.svh"
module testbench;
    import pac_pkg::*;
    logic                   clk, rst, ce, wr, rd, rd_q, t0, t1, t3, prev;
    logic [`PAC_ADDR_W-1:0] addr;
    logic [7:0]             wdata, rdata, pad_in, pad_out, pad_oe, ana, ext, lat, own;
    pac_osc_e               osc;
    logic [7:0]             exp_q[$];
    int                     bad_count, total_checks, flips;

    pac_port_a DUT (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .analog_en_o(ana), .osc_mode_o(osc), .timer_zero_clock_in_o(t0), .timer_one_clock_in_o(t1),
        .timer_three_gate_in_o(t3));
    pac_pad_model pads (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_i(ext), .pad_in_o(pad_in));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic wr_reg(input logic [`PAC_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // the expected value is noted at request time; the monitor pops it when the data stands
    task automatic rd_reg(input logic [`PAC_ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg

    // write then read with no idle cycle between the two strobes
    task automatic wr_rd(input logic [`PAC_ADDR_W-1:0] aw, input logic [7:0] d,
                         input logic [`PAC_ADDR_W-1:0] ar, input logic [7:0] e);
        @(posedge clk);
        wr <= 1'b1;
        addr <= aw;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= ar;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : wr_rd

    // register change reaches the pins one edge later and the timer inputs two edges later; one spare edge for margin
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic reset_check();
        rd_reg(`PAC_ADDR_LATCH, 8'h00);
        rd_reg(`PAC_ADDR_DIR, 8'hFF);
        rd_reg(`PAC_ADDR_ANALOG_PIN_SELECT, 8'h1F);
        rd_reg(`PAC_ADDR_OSC, 8'h00);
        rd_reg(`PAC_ADDR_LEVEL, ext & 8'hD0);
        rd_reg(3'h5, 8'h00);
        rd_reg(3'h7, 8'h00);
        settle();
        chk8("analog enables", 8'h2F, ana);
        chk8("output enables", 8'h00, pad_oe);
    endtask : reset_check

    always @(posedge clk)
    begin
        if (rd_q)
            chk8("read data", exp_q.pop_front(), rdata);
        rd_q <= rd & ce;
    end

    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        rd_q = 1'b0;
        addr = '0;
        wdata = 8'h00;
        ext = 8'h00;
        bad_count = 0;
        total_checks = 0;
        void'($urandom(32'h7C2788FC));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        reset_check();
        ext <= 8'($urandom);
        settle();
        rd_reg(`PAC_ADDR_LEVEL, ext & 8'hD0);
        lat = 8'($urandom);
        wr_rd(`PAC_ADDR_LEVEL, lat, `PAC_ADDR_LATCH, lat);
        wr_reg(`PAC_ADDR_LATCH, ~lat);
        rd_reg(`PAC_ADDR_LATCH, ~lat);
        wr_reg(`PAC_ADDR_DIR, 8'h00);
        settle();
        chk8("output enables", 8'hFF, pad_oe);
        chk8("pad drive", ~lat, pad_out);
        chk8("timer zero clock", {7'h00, ~lat[4]}, {7'h00, t0});
        chk8("timer one clock", {7'h00, ~lat[5]}, {7'h00, t1});
        // analog use keeps the direction bits set
        wr_reg(`PAC_ADDR_DIR, 8'hFF);
        wr_reg(`PAC_ADDR_ANALOG_PIN_SELECT, 8'h00);
        settle();
        chk8("analog enables", 8'h00, ana);
        rd_reg(`PAC_ADDR_LEVEL, ext);
        chk8("timer one clock", {7'h00, ext[5]}, {7'h00, t1});
        chk8("timer three gate", {7'h00, ext[5]}, {7'h00, t3});
        wr_reg(`PAC_ADDR_DIR, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            own = (m == 0) ? 8'h00 : (m == 1) ? 8'h40 : 8'hC0;
            wr_reg(`PAC_ADDR_OSC, 8'h00);
            wr_reg(`PAC_ADDR_LATCH, lat);
            wr_reg(`PAC_ADDR_OSC, 8'(m));
            settle();
            chk8("oscillator mode", 8'(m), {6'h00, osc});
            chk8("osc pin enables", (m < 2) ? 8'hC0 : (m == 2) ? 8'h40 : 8'h00, pad_oe & 8'hC0);
            flips = 0;
            prev = pad_out[6];
            repeat (16)
            begin
                @(posedge clk);
                #1;
                flips += int'(pad_out[6] !== prev);
                prev = pad_out[6];
            end
            chk8("clock out edges", (m == 1 || m == 2) ? 8'h08 : 8'h00, 8'(flips));
            rd_reg(`PAC_ADDR_LATCH, lat & ~own);
            wr_reg(`PAC_ADDR_LATCH, ~lat);
            rd_reg(`PAC_ADDR_LATCH, ~lat & ~own);
            wr_reg(`PAC_ADDR_OSC, 8'h00);
            rd_reg(`PAC_ADDR_LATCH, (~lat & ~own) | (lat & own));
        end
        lat = (~lat & 8'h3F) | (lat & 8'hC0);
        // a disabled clock enable must swallow the strobe
        ce <= 1'b0;
        wr_reg(`PAC_ADDR_LATCH, 8'h5A);
        ce <= 1'b1;
        rd_reg(`PAC_ADDR_LATCH, lat);
        // the read data stand one edge later; reset would clear them before the monitor looks
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reset_check();
        settle();
        end_sim();
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        bad_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
